// ### logic/fbcfe_defines.svh
// Constants for the flash bus command front end host controller
`ifndef FBCFE_DEFINES_SVH
`define FBCFE_DEFINES_SVH

`define FBCFE_CLK_NS 40
`define FBCFE_RESET_LOW_NS 100
`define FBCFE_RESET_LOW_CYC ((`FBCFE_RESET_LOW_NS + `FBCFE_CLK_NS - 1) / `FBCFE_CLK_NS)
`define FBCFE_WAKE_NS 600
`define FBCFE_WAKE_CYC ((`FBCFE_WAKE_NS + `FBCFE_CLK_NS - 1) / `FBCFE_CLK_NS)
`define FBCFE_SETUP_CYC 2
`define FBCFE_PULSE_CYC 3
`define FBCFE_HOLD_CYC 2

`endif

// ### logic/fbcfe_pkg.sv
// Types for the flash bus command front end host controller
`default_nettype none
package fbcfe_pkg;
  typedef enum logic [1:0] {
    FBCFE_OP_READ,
    FBCFE_OP_WRITE,
    FBCFE_OP_RESET
  } fbcfe_op_type;

  typedef struct packed {
    fbcfe_op_type op;
    logic [19:0] addr;
    logic [7:0] data;
  } fbcfe_req_type;

  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic reset_powerdown_n;
  } fbcfe_ctl_type;
endpackage
`default_nettype wire

// ### logic/fbcfe_host.sv
// Host-side bus sequencer that drives the parallel flash pins
`include "fbcfe_defines.svh"
`default_nettype none
module fbcfe_host
  import fbcfe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire fbcfe_req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [19:0] address_lines,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [7:0] data_lines_in,
  output fbcfe_ctl_type ctl
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_RST_LOW, S_WAKE} fbcfe_st_type;

  localparam int CW = 5;
  localparam logic [CW-1:0] SETUP_C = CW'(`FBCFE_SETUP_CYC);
  localparam logic [CW-1:0] PULSE_C = CW'(`FBCFE_PULSE_CYC);
  localparam logic [CW-1:0] HOLD_C = CW'(`FBCFE_HOLD_CYC);
  localparam logic [CW-1:0] RSTL_C = CW'(`FBCFE_RESET_LOW_CYC);
  localparam logic [CW-1:0] WAKE_C = CW'(`FBCFE_WAKE_CYC);

  // ==========================================
  // Input synchroniser for data pins, two flops per bit
  logic [7:0] din_s1_q, din_s2_q;
  for (genvar b = 0; b < 8; b++) begin : g_sync
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        din_s1_q[b] <= 1'b0;
        din_s2_q[b] <= 1'b0;
      end else begin
        din_s1_q[b] <= data_lines_in[b];
        din_s2_q[b] <= din_s1_q[b];
      end
    end
  end

  // ==========================================
  // Sequencer
  fbcfe_st_type st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  fbcfe_op_type op_q;
  logic [19:0] addr_q;
  logic [7:0] wdata_q;

  wire cnt_done = (cnt_q == '0);
  wire take = (st_q == S_IDLE) && req_valid;
  wire is_rd = (op_q == FBCFE_OP_READ);
  wire is_wr = (op_q == FBCFE_OP_WRITE);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - CW'(1);
    case (st_q)
      S_IDLE: begin
        if (req_valid) begin
          if (req.op == FBCFE_OP_RESET) begin
            st_d = S_RST_LOW;
            cnt_d = RSTL_C;
          end else begin
            st_d = S_SETUP;
            cnt_d = SETUP_C;
          end
        end
      end
      S_SETUP: begin
        if (cnt_done) begin
          st_d = S_PULSE;
          cnt_d = PULSE_C;
        end
      end
      S_PULSE: begin
        if (cnt_done) begin
          st_d = S_HOLD;
          cnt_d = HOLD_C;
        end
      end
      S_HOLD: begin
        if (cnt_done) begin
          st_d = S_IDLE;
        end
      end
      S_RST_LOW: begin
        if (cnt_done) begin
          st_d = S_WAKE;
          cnt_d = WAKE_C;
        end
      end
      S_WAKE: begin
        if (cnt_done) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // Pin levels for the next cycle
  wire sel_d = (st_d == S_SETUP) || (st_d == S_PULSE) || (st_d == S_HOLD);
  wire oe_d = is_rd && ((st_d == S_PULSE) || (st_d == S_HOLD)) && (st_q != S_IDLE);
  // strobe low only in pulse, rises before select
  wire we_d = is_wr && (st_d == S_PULSE) && (st_q != S_IDLE);
  // reset held low for the counted time
  wire rp_d = (st_d != S_RST_LOW);
  wire drive_d = is_wr && sel_d && (st_q != S_IDLE);
  wire sample = is_rd && (st_q == S_HOLD) && cnt_done;

  // ==========================================
  // State and counter
  // Leaving reset starts in the wake wait so the first command comes late enough
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_WAKE;
      cnt_q <= WAKE_C;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================
  // Request latch
  // one byte per request; a two-write command is two requests
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q <= FBCFE_OP_READ;
      addr_q <= 20'h0_0000;
      wdata_q <= 8'h00;
    end else if (take) begin
      op_q <= req.op;
      addr_q <= req.addr;
      wdata_q <= req.data;
    end
  end

  // ==========================================
  // Control pins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl <= '{chip_select_n: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
               reset_powerdown_n: 1'b0};
    end else begin
      ctl.chip_select_n <= ~sel_d;
      // output enable high except in the pulse and hold of a read
      ctl.output_enable_n <= ~oe_d;
      ctl.write_strobe_n <= ~we_d;
      ctl.reset_powerdown_n <= rp_d;
    end
  end

  // ==========================================
  // Address and data pins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      address_lines <= 20'h0_0000;
    end else begin
      address_lines <= take ? req.addr : addr_q;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_lines_out <= 8'h00;
    end else begin
      data_lines_out <= take ? req.data : wdata_q;
    end
  end

  // Host drives the data lines only inside a write cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_lines_oe <= 1'b0;
    end else begin
      data_lines_oe <= drive_d;
    end
  end

  // ==========================================
  // Request and response handshake
  // no new request until wake interval over
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (st_d == S_IDLE);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= sample;
    end
  end

  // Read byte holds until the next read completes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_data <= 8'h00;
    end else if (sample) begin
      rsp_data <= din_s2_q;
    end
  end
endmodule
`default_nettype wire

// ### sim/fbcfe_host_asserts.sv
// Pin timing checks for the flash host sequencer
`default_nettype none
module fbcfe_host_asserts
  import fbcfe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req_ready,
  input wire logic [19:0] address_lines,
  input wire logic data_lines_oe,
  input wire fbcfe_ctl_type ctl
);
  timeunit 1ns / 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_read_levels: assert property (
    !ctl.output_enable_n |-> ctl.write_strobe_n && !ctl.chip_select_n && !data_lines_oe)
    else $error("read with bad pin levels");
  a_write_select: assert property (
    !ctl.write_strobe_n |-> !ctl.chip_select_n && data_lines_oe && ctl.output_enable_n)
    else $error("write strobe without select");
  a_strobe_first: assert property (
    $rose(ctl.write_strobe_n) |-> !ctl.chip_select_n)
    else $error("select rose before strobe");
  a_addr_held: assert property (
    !ctl.write_strobe_n |=> $stable(address_lines))
    else $error("address moved during strobe");
  a_reset_width: assert property (
    $fell(ctl.reset_powerdown_n) |-> !ctl.reset_powerdown_n [*3])
    else $error("reset pulse too short");
  a_wake_wait: assert property (
    $rose(ctl.reset_powerdown_n) |-> (!req_ready && ctl.write_strobe_n) [*8])
    else $error("write too soon after reset");
endmodule
bind fbcfe_host fbcfe_host_asserts chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .req_ready(req_ready), .address_lines(address_lines), .data_lines_oe(data_lines_oe),
  .ctl(ctl));
`default_nettype wire

// ### sim/fbcfe_flash_model.sv
// Behavioural flash device on the host pins
`default_nettype none
module fbcfe_flash_model
  import fbcfe_pkg::*;
(
  input wire logic [19:0] address_lines,
  input wire logic [7:0] data_lines_out,
  input wire fbcfe_ctl_type ctl,
  output logic [7:0] data_lines_in
);
  timeunit 1ns / 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic stat = 1'b0;
  logic prog = 1'b0;
  wire wr_n = ctl.write_strobe_n | ctl.chip_select_n;
  wire drive = !(ctl.chip_select_n | ctl.output_enable_n) & ctl.reset_powerdown_n;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // reset gives array mode and aborts a pending write
  always @(negedge ctl.reset_powerdown_n) {stat, prog} = 2'b00;
  always @(posedge wr_n) begin
    if (ctl.reset_powerdown_n === 1'b1) begin
      if (prog) mem[address_lines[7:0]] = data_lines_out;
      stat = data_lines_out == 8'h70;
      prog = data_lines_out == 8'h40;
    end
  end
  // status read needs no program supply
  always @* begin
    if (drive) last = stat ? 8'h80 : mem[address_lines[7:0]];
    data_lines_in = drive ? last : ~last;
  end
endmodule
`default_nettype wire

// ### sim/fbcfe_host_test.sv
// Self-checking bench for the flash host sequencer
`default_nettype none
module fbcfe_host_test
  import fbcfe_pkg::*;
;
  timeunit 1ns / 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_ready, rsp_valid, oe;
  fbcfe_req_type req = '0;
  fbcfe_ctl_type ctl;
  logic [7:0] rsp_data, dq_out, dq_in;
  logic [19:0] addr;
  int num_errors = 0, total_checks = 0, cyc = 0;
  fbcfe_host dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .address_lines(addr),
    .data_lines_out(dq_out), .data_lines_oe(oe), .data_lines_in(dq_in), .ctl(ctl));
  fbcfe_flash_model flash (.address_lines(addr), .data_lines_out(dq_out), .ctl(ctl),
    .data_lines_in(dq_in));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic results();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  task automatic check(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(fbcfe_op_type op, logic [19:0] a, logic [7:0] d, logic [7:0] exp);
    int n;
    for (n = 0; n < 60 && req_ready !== 1'b1; n++) @(posedge ref_clk) #1;
    req = '{op, a, d};
    req_valid = 1'b1;
    @(posedge ref_clk) #1;
    req_valid = 1'b0;
    for (n = 0; n < 40 && op == FBCFE_OP_READ && rsp_valid !== 1'b1; n++) @(posedge ref_clk) #1;
    if (op == FBCFE_OP_READ) check({7'h00, rsp_valid}, 8'h01);
    if (op == FBCFE_OP_READ) check(rsp_data, exp);
  endtask
  task automatic t_boot();
    run(FBCFE_OP_READ, 20'h0_0005, 8'h00, 8'hFF);
  endtask
  task automatic t_write();
    run(FBCFE_OP_WRITE, 20'h0_0000, 8'h40, 8'h00);
    run(FBCFE_OP_WRITE, 20'hF_FF05, 8'h5A, 8'h00);
    run(FBCFE_OP_WRITE, 20'h0_0000, 8'hFF, 8'h00);
    run(FBCFE_OP_READ, 20'hF_FF05, 8'h00, 8'h5A);
  endtask
  task automatic t_reset();
    run(FBCFE_OP_WRITE, 20'h0_0000, 8'h70, 8'h00);
    run(FBCFE_OP_READ, 20'h0_0000, 8'h00, 8'h80);
    run(FBCFE_OP_RESET, 20'h0_0000, 8'h00, 8'h00);
    run(FBCFE_OP_READ, 20'h0_0005, 8'h00, 8'h5A);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_boot();
    t_write();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
